// >>> amcof_fmt.sv
// per-channel output coding: two's complement, randomizer, alternate polarity, test patterns
`timescale 1ns/1ps
module amcof_fmt (
    input  logic                 [15:0] data,
    input  logic                        ovf,
    input  logic                        twos,
    input  logic                        rnd,
    input  logic                        abp,
    input  logic                        tp_en,
    input  amcof_pkg::amcof_tp_t        tp_sel,
    input  logic                        phase,
    output logic                 [15:0] bits,
    output logic                        ovf_o
);
    always_comb begin
        bits = data;
        ovf_o = ovf;
        if (twos) begin
            bits[amcof_pkg::DW-1] = ~data[amcof_pkg::DW-1];
        end
        // randomizer and polarity flip are applied independently of each other
        if (rnd) begin
            bits[amcof_pkg::DW-1:1] = bits[amcof_pkg::DW-1:1] ^ {(amcof_pkg::DW-1){bits[0]}};
        end
        if (abp) begin
            bits = bits ^ amcof_pkg::ODD_MASK;
        end
        // overflow and even bits untouched by the polarity flip
        if (tp_en) begin
            unique case (tp_sel)
                amcof_pkg::TP_ONES: begin
                    bits = '1;
                    ovf_o = 1'b1;
                end
                amcof_pkg::TP_ZEROS: begin
                    bits = '0;
                    ovf_o = 1'b0;
                end
                amcof_pkg::TP_ALT: begin
                    bits = {amcof_pkg::DW{~phase}};
                    ovf_o = ~phase;
                end
                amcof_pkg::TP_CHECK: begin
                    bits = phase ? ~amcof_pkg::CHECK_A : amcof_pkg::CHECK_A;
                    ovf_o = ~phase;
                end
            endcase
        end
    end
endmodule

// >>> amcof_host.sv
// host model for the serial configuration port
`timescale 1ns/1ps
module amcof_host (
    input  logic mclk,
    input  logic sdo_wire,
    output logic cs_n,
    output logic sck,
    output logic sdi
);
    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        sdi  = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // bits past sixteen are ones so any extra sampling corrupts the word
    task automatic xfer(input logic [15:0] word, input int nbits, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge mclk);
        cs_n <= 1'b0;
        w(4);
        for (int i = 0; i < nbits; i++) begin
            sdi <= (i < 16) ? word[15-i] : 1'b1;
            w(4);
            sck <= 1'b1;
            #1;
            if (i >= 8 && i < 16) rd = {rd[6:0], sdo_wire};
            w(4);
            sck <= 1'b0;
        end
        w(4);
        cs_n <= 1'b1;
        sdi  <= ~sdi;
        w(4);
    endtask
    task automatic strap(input logic c, input logic s, input logic d);
        @(posedge mclk);
        cs_n <= c;
        sck  <= s;
        sdi  <= d;
    endtask
endmodule

// >>> amcof_pkg.sv
// shared constants and types for the converter mode/format block
package amcof_pkg;
    localparam int DW = 16;
    localparam int SW = 16;
    localparam int HDR = 8;
    localparam int CNT_W = 5;
    localparam int NREG = 5;
    localparam logic [6:0] ADDR_RST = 7'h00;
    localparam logic [6:0] ADDR_PWR = 7'h01;
    localparam logic [6:0] ADDR_TIM = 7'h02;
    localparam logic [6:0] ADDR_DRV = 7'h03;
    localparam logic [6:0] ADDR_FMT = 7'h04;
    localparam int RST_BIT = 7;
    localparam int TIM_DCS = 0;
    localparam int DRV_MODE = 0;
    localparam int DRV_DIS = 2;
    localparam int DRV_TERM = 3;
    localparam int DRV_CUR = 4;
    localparam int FMT_TWOS = 0;
    localparam int FMT_RAND = 1;
    localparam int FMT_ABP = 2;
    localparam int FMT_TP_EN = 3;
    localparam int FMT_TP = 4;
    localparam logic [7:0] REG_RST_VAL = 8'h00;
    localparam logic [1:0] PWR_NORMAL = 2'h0;
    localparam logic [1:0] PWR_NAP2 = 2'h1;
    localparam logic [1:0] PWR_NAP_BOTH = 2'h2;
    localparam logic [1:0] PWR_SLEEP = 2'h3;
    localparam logic [1:0] MODE_CMOS = 2'h0;
    localparam logic [1:0] MODE_LVDS = 2'h2;
    localparam logic [2:0] CUR_3P5 = 3'h0;
    localparam logic [15:0] ODD_MASK = 16'haaaa;
    localparam logic [15:0] CHECK_A = 16'h5555;
    typedef enum logic [1:0] {
        TP_ONES  = 2'b00,
        TP_ZEROS = 2'b01,
        TP_ALT   = 2'b10,
        TP_CHECK = 2'b11
    } amcof_tp_t;
    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_SHIFT = 2'b01,
        S_DONE  = 2'b10,
        S_HOLD  = 2'b11
    } amcof_sst_t;
endpackage

// >>> amcof_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module amcof_sync #(
    parameter int W = 1
) (
    input  logic         mclk,
    input  logic         rst,
    input  logic         ce,
    input  logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } amcof_sync_st_t;

    amcof_sync_st_t st_q;
    amcof_sync_st_t st_d;

    // first stage feeds only the second stage
    always_comb begin
        st_d.s1 = d;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign q = st_q.s2;
endmodule

// >>> amcof_top.sv
// mode configuration port, power and output-format control for a dual-channel converter
// Notes on behaviour
// - polarity mode inverts odd data bits per channel
// - even bits, overflow, output clock pass unchanged
// - randomizer and polarity flip enable independently
// - polarity enable lives in format register, serial only
// - test patterns: ones, zeros, alternating, checkerboard
// - enabled test pattern overrides all other formatting
// - output disable floats data, overflow and clock
// - channel 1 naps only with channel 2
// - parallel select high makes serial pins static straps
// - parallel chip-select sets duty stabilizer off/on
// - parallel clock pin picks CMOS or LVDS 3.5mA
// - two-bit power code selects run, nap or sleep
// - sample first 16 rising edges, end on select high
// - word is r/w flag, 7 address, 8 data
// - write flag low stores data in register
// - read flag high shifts register out, no store
// - first command is reset via bit 7
// - reset bit clears itself after the reset
`timescale 1ns/1ps
module amcof_top (
    input  logic        mclk,
    input  logic        rst,
    input  logic        ce,
    input  logic        parallel_serial_select,
    input  logic        cs_n,
    input  logic        sck,
    input  logic        sdi,
    input  logic        sdo_i,
    output logic        sdo_o,
    output logic        sdo_oe,
    input  logic        sample_valid,
    input  logic [15:0] ch1_data,
    input  logic        ch1_ovf,
    input  logic [15:0] ch2_data,
    input  logic        ch2_ovf,
    output logic [15:0] ch1_conversion_output_bits,
    output logic        ch1_overflow_flag,
    output logic [15:0] ch2_conversion_output_bits,
    output logic        ch2_overflow_flag,
    output logic        output_data_clock,
    output logic        outputs_enable,
    output logic        dcs_on,
    output logic [1:0]  output_mode,
    output logic [2:0]  lvds_current,
    output logic        lvds_term_on,
    output logic        ch1_nap,
    output logic        ch2_nap,
    output logic        sleep
);
    typedef struct packed {
        amcof_pkg::amcof_sst_t       sst;
        logic                        prev_sck;
        logic                        prev_cs_n;
        logic [amcof_pkg::CNT_W-1:0] cnt;
        logic [amcof_pkg::SW-1:0]    shreg;
        logic [7:0]                  rd_sh;
        logic                        rd_act;
        logic [amcof_pkg::NREG-1:0][7:0] regs;
        logic                        srst;
        logic                        sdo_o;
        logic                        sdo_oe;
        logic [15:0]                 ch1_bits;
        logic                        ch1_ovf;
        logic [15:0]                 ch2_bits;
        logic                        ch2_ovf;
        logic                        out_clk;
        logic                        out_en;
        logic                        tp_phase;
        logic                        dcs_on;
        logic [1:0]                  out_mode;
        logic [2:0]                  lvds_cur;
        logic                        int_term;
        logic                        ch1_nap;
        logic                        ch2_nap;
        logic                        sleep;
    } amcof_st_t;

    amcof_st_t q;
    amcof_st_t d;

    logic [4:0]  pin_s;
    logic        par_s;
    logic        cs_s;
    logic        sck_s;
    logic        sdi_s;
    logic        sdo_s;
    logic        sck_rise;
    logic        sck_fall;
    logic [7:0]  fmt_reg;
    logic [7:0]  drv_reg;
    logic        fmt_twos;
    logic        fmt_rand;
    logic        fmt_abp;
    logic        fmt_tp;
    amcof_pkg::amcof_tp_t fmt_sel;
    logic [15:0] f1_bits;
    logic        f1_ovf;
    logic [15:0] f2_bits;
    logic        f2_ovf;

    // every configuration pin crosses two flops before anything reads it; sample data and sample_valid are read directly
    amcof_sync #(
        .W(5)
    ) u_sync (
        .mclk (mclk),
        .rst  (rst),
        .ce   (ce),
        .d    ({parallel_serial_select, cs_n, sck, sdi, sdo_i}),
        .q    (pin_s)
    );

    assign par_s = pin_s[4];
    assign cs_s = pin_s[3];
    assign sck_s = pin_s[2];
    assign sdi_s = pin_s[1];
    assign sdo_s = pin_s[0];
    assign sck_rise = sck_s & ~q.prev_sck;
    assign sck_fall = ~sck_s & q.prev_sck;

    function automatic logic addr_ok(input logic [6:0] a);
        return a <= amcof_pkg::ADDR_FMT;
    endfunction

    function automatic logic [2:0] addr_idx(input logic [6:0] a);
        return a[2:0];
    endfunction

    // format controls come only from the serial registers; straps cannot set them
    assign fmt_reg = par_s ? 8'h00 : q.regs[addr_idx(amcof_pkg::ADDR_FMT)];
    assign drv_reg = q.regs[addr_idx(amcof_pkg::ADDR_DRV)];
    assign fmt_twos = fmt_reg[amcof_pkg::FMT_TWOS];
    assign fmt_rand = fmt_reg[amcof_pkg::FMT_RAND];
    assign fmt_abp = fmt_reg[amcof_pkg::FMT_ABP];
    assign fmt_tp = fmt_reg[amcof_pkg::FMT_TP_EN];
    assign fmt_sel = amcof_pkg::amcof_tp_t'(fmt_reg[amcof_pkg::FMT_TP+1:amcof_pkg::FMT_TP]);

    amcof_fmt u_fmt1 (
        .data   (ch1_data),
        .ovf    (ch1_ovf),
        .twos   (fmt_twos),
        .rnd    (fmt_rand),
        .abp    (fmt_abp),
        .tp_en  (fmt_tp),
        .tp_sel (fmt_sel),
        .phase  (q.tp_phase),
        .bits   (f1_bits),
        .ovf_o  (f1_ovf)
    );

    amcof_fmt u_fmt2 (
        .data   (ch2_data),
        .ovf    (ch2_ovf),
        .twos   (fmt_twos),
        .rnd    (fmt_rand),
        .abp    (fmt_abp),
        .tp_en  (fmt_tp),
        .tp_sel (fmt_sel),
        .phase  (q.tp_phase),
        .bits   (f2_bits),
        .ovf_o  (f2_ovf)
    );

    always_comb begin
        logic [1:0] pwr;
        logic [6:0] wa;
        pwr = amcof_pkg::PWR_NORMAL;
        wa = q.shreg[14:8];
        d = q;
        d.prev_sck = sck_s;
        d.prev_cs_n = cs_s;
        d.srst = 1'b0;
        d.sdo_o = 1'b0;

        unique case (q.sst)
            amcof_pkg::S_IDLE: begin
                if (!par_s && !cs_s && q.prev_cs_n) begin
                    d.sst = amcof_pkg::S_SHIFT;
                    d.cnt = '0;
                    d.rd_act = 1'b0;
                end
            end
            amcof_pkg::S_SHIFT: begin
                // a short word is dropped without touching the registers
                if (cs_s || par_s) begin
                    d.sst = amcof_pkg::S_IDLE;
                    d.rd_act = 1'b0;
                end else begin
                    if (sck_rise) begin
                        d.shreg = {q.shreg[amcof_pkg::SW-2:0], sdi_s};
                        d.cnt = q.cnt + 5'h01;
                        if (q.cnt == 5'(amcof_pkg::HDR - 1) && q.shreg[6]) begin
                            d.rd_sh = addr_ok({q.shreg[5:0], sdi_s}) ?
                                      q.regs[addr_idx({q.shreg[5:0], sdi_s})] : 8'h00;
                            d.rd_act = 1'b1;
                        end
                        if (q.cnt == 5'(amcof_pkg::SW - 1)) begin
                            d.sst = amcof_pkg::S_DONE;
                        end
                    end
                    // host samples on rising edges, so the next bit goes out on the falling one
                    if (sck_fall && q.rd_act && q.cnt > 5'(amcof_pkg::HDR)) begin
                        d.rd_sh = {q.rd_sh[6:0], 1'b0};
                    end
                end
            end
            amcof_pkg::S_DONE: begin
                d.sst = amcof_pkg::S_HOLD;
                d.rd_act = 1'b0;
                if (!q.shreg[amcof_pkg::SW-1] && addr_ok(wa)) begin
                    d.regs[addr_idx(wa)] = q.shreg[7:0];
                    if (wa == amcof_pkg::ADDR_RST && q.shreg[amcof_pkg::RST_BIT]) begin
                        d.srst = 1'b1;
                    end
                end
            end
            amcof_pkg::S_HOLD: begin
                // edges past the sixteenth are ignored until select rises
                if (cs_s || par_s) begin
                    d.sst = amcof_pkg::S_IDLE;
                end
            end
        endcase

        // reset pulse wipes every register, its own trigger bit included
        if (q.srst) begin
            for (int i = 0; i < amcof_pkg::NREG; i++) begin
                d.regs[i] = amcof_pkg::REG_RST_VAL;
            end
        end

        // open drain: pull low only for a zero bit of a read
        d.sdo_oe = d.rd_act & ~d.rd_sh[7] & ~par_s;

        if (par_s) begin
            d.dcs_on = cs_s;
            d.out_mode = sck_s ? amcof_pkg::MODE_LVDS : amcof_pkg::MODE_CMOS;
            d.lvds_cur = amcof_pkg::CUR_3P5;
            d.int_term = 1'b0;
            d.out_en = 1'b1;
            pwr = {sdi_s, sdo_s};
        end else begin
            d.dcs_on = q.regs[addr_idx(amcof_pkg::ADDR_TIM)][amcof_pkg::TIM_DCS];
            d.out_mode = drv_reg[amcof_pkg::DRV_MODE+1:amcof_pkg::DRV_MODE];
            d.lvds_cur = drv_reg[amcof_pkg::DRV_CUR+2:amcof_pkg::DRV_CUR];
            d.int_term = drv_reg[amcof_pkg::DRV_TERM];
            d.out_en = ~drv_reg[amcof_pkg::DRV_DIS];
            pwr = q.regs[addr_idx(amcof_pkg::ADDR_PWR)][1:0];
            if (q.srst) begin
                pwr = amcof_pkg::PWR_SLEEP;
            end
        end

        // no code exists that naps channel 1 alone
        d.ch2_nap = (pwr == amcof_pkg::PWR_NAP2) || (pwr == amcof_pkg::PWR_NAP_BOTH);
        d.ch1_nap = (pwr == amcof_pkg::PWR_NAP_BOTH);
        d.sleep = (pwr == amcof_pkg::PWR_SLEEP);

        if (sample_valid) begin
            d.ch1_bits = f1_bits;
            d.ch1_ovf = f1_ovf;
            d.ch2_bits = f2_bits;
            d.ch2_ovf = f2_ovf;
            d.tp_phase = ~q.tp_phase;
            d.out_clk = ~q.out_clk;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign sdo_o = q.sdo_o;
    assign sdo_oe = q.sdo_oe;
    assign ch1_conversion_output_bits = q.ch1_bits;
    assign ch1_overflow_flag = q.ch1_ovf;
    assign ch2_conversion_output_bits = q.ch2_bits;
    assign ch2_overflow_flag = q.ch2_ovf;
    assign output_data_clock = q.out_clk;
    assign outputs_enable = q.out_en;
    assign dcs_on = q.dcs_on;
    assign output_mode = q.out_mode;
    assign lvds_current = q.lvds_cur;
    assign lvds_term_on = q.int_term;
    assign ch1_nap = q.ch1_nap;
    assign ch2_nap = q.ch2_nap;
    assign sleep = q.sleep;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst || !ce);

    sequence s_plain_abp;
        sample_valid && fmt_abp && !fmt_tp && !fmt_rand && !fmt_twos;
    endsequence

    sequence s_wr_fmt;
        q.sst == amcof_pkg::S_DONE && !q.shreg[15] && q.shreg[14:8] == amcof_pkg::ADDR_FMT;
    endsequence

    a_abp_odd_inv: assert property (s_plain_abp |=> q.ch1_bits == ($past(ch1_data) ^ amcof_pkg::ODD_MASK))
        else $error("odd bits not inverted under polarity mode");

    a_abp_even_keep: assert property (s_plain_abp |=> ((q.ch2_bits & ~amcof_pkg::ODD_MASK) ==
        ($past(ch2_data) & ~amcof_pkg::ODD_MASK)) && q.ch2_ovf == $past(ch2_ovf))
        else $error("even bits or overflow changed under polarity mode");

    a_rand_abp_both: assert property ((sample_valid && fmt_abp && fmt_rand && !fmt_tp && !fmt_twos) |=>
        q.ch1_bits == ($past(ch1_data) ^ {{15{$past(ch1_data[0])}}, 1'b0} ^ amcof_pkg::ODD_MASK))
        else $error("randomizer and polarity flip do not combine");

    a_tp_ones_win: assert property ((sample_valid && fmt_tp && fmt_sel == amcof_pkg::TP_ONES) |=>
        q.ch1_bits == 16'hffff && q.ch1_ovf && q.ch2_bits == 16'hffff)
        else $error("all-ones pattern not forced");

    a_tp_alt_toggle: assert property ((sample_valid && fmt_tp && fmt_sel == amcof_pkg::TP_ALT) |=>
        q.ch1_ovf == !$past(q.tp_phase) && q.ch1_bits == {16{q.ch1_ovf}})
        else $error("alternating pattern wrong");

    a_out_disable: assert property ((!par_s && drv_reg[amcof_pkg::DRV_DIS]) |=> !q.out_en)
        else $error("outputs still enabled while disabled");

    a_nap_pair: assert property (q.ch1_nap |-> q.ch2_nap)
        else $error("channel 1 napping alone");

    a_par_dcs: assert property (par_s |=> q.dcs_on == $past(cs_s))
        else $error("strap duty stabilizer mismatch");

    a_par_lvds: assert property ((par_s && sck_s) |=> q.out_mode == amcof_pkg::MODE_LVDS &&
        q.lvds_cur == amcof_pkg::CUR_3P5 && !q.int_term)
        else $error("strap output mode wrong");

    a_par_sleep: assert property ((par_s && sdi_s && sdo_s) |=> q.sleep && !q.ch1_nap)
        else $error("strap sleep code ignored");

    a_bit_cap: assert property (q.cnt <= 5'(amcof_pkg::SW))
        else $error("more than sixteen bits taken");

    a_wr_commit: assert property (s_wr_fmt |=> q.regs[4] == $past(q.shreg[7:0]))
        else $error("write not stored");

    a_rd_keep: assert property ((q.sst == amcof_pkg::S_DONE && q.shreg[15]) |=> q.regs == $past(q.regs))
        else $error("read changed a register");

    a_short_drop: assert property ((q.sst == amcof_pkg::S_SHIFT && cs_s) |=> q.regs == $past(q.regs))
        else $error("short word changed a register");

    a_srst_clear: assert property (q.srst |=> q.regs == '0 && !q.srst ##1 !q.srst)
        else $error("software reset did not clear");
endmodule

// >>> test_amcof_top.sv
// self-checking bench for the mode configuration and output format block
`timescale 1ns/1ps
module test_amcof_top;
    logic        mclk, rst, ce, psel, strap_sdo, sample_valid, ch1_ovf, ch2_ovf;
    logic [15:0] ch1_data, ch2_data, o1, o2;
    logic        cs_n, sck, sdi, sdo_o, sdo_oe, sdo_wire, sdo_i;
    logic        of1, of2, odc, oen, dcs_on, lvds_term_on, ch1_nap, ch2_nap, sleep;
    logic [1:0]  output_mode;
    logic [2:0]  lvds_current;
    int          miscompares, total_checks, cycles;
    assign sdo_wire = sdo_oe ? sdo_o : 1'b1;
    assign sdo_i    = psel ? strap_sdo : sdo_wire;
    amcof_host amcof_host_i (.mclk(mclk), .sdo_wire(sdo_wire), .cs_n(cs_n), .sck(sck), .sdi(sdi));
    amcof_top amcof_top_i (.mclk(mclk), .rst(rst), .ce(ce), .parallel_serial_select(psel), .cs_n(cs_n),
        .sck(sck), .sdi(sdi), .sdo_i(sdo_i), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .sample_valid(sample_valid),
        .ch1_data(ch1_data), .ch1_ovf(ch1_ovf), .ch2_data(ch2_data), .ch2_ovf(ch2_ovf),
        .ch1_conversion_output_bits(o1), .ch1_overflow_flag(of1), .ch2_conversion_output_bits(o2),
        .ch2_overflow_flag(of2), .output_data_clock(odc), .outputs_enable(oen), .dcs_on(dcs_on),
        .output_mode(output_mode), .lvds_current(lvds_current), .lvds_term_on(lvds_term_on),
        .ch1_nap(ch1_nap), .ch2_nap(ch2_nap), .sleep(sleep));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic final_report();
        if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] rd;
        amcof_host_i.xfer({1'b0, a, d}, 16, rd);
    endtask
    // data bits of a read word are ones, which must not be stored
    task automatic rdreg(input logic [6:0] a, output logic [7:0] d);
        amcof_host_i.xfer({1'b1, a, 8'hff}, 16, d);
    endtask
    task automatic smp(input logic [15:0] d1, input logic v1, input logic [15:0] d2, input logic v2);
        @(posedge mclk);
        sample_valid <= 1'b1;
        ch1_data     <= d1;
        ch1_ovf      <= v1;
        ch2_data     <= d2;
        ch2_ovf      <= v2;
        @(posedge mclk);
        sample_valid <= 1'b0;
        #1;
    endtask
    task automatic chk_pwr(input logic [1:0] c);
        chk(sleep, c == 2'h3);
        if (c != 2'h3) begin
            chk(ch2_nap, c != 2'h0);
            chk(ch1_nap, c == 2'h2);
        end
    endtask
    task automatic t_reset();
        logic [7:0] rd;
        wr(amcof_pkg::ADDR_RST, 8'h80);
        wr(amcof_pkg::ADDR_TIM, 8'h01);
        chk(dcs_on, 1'b1);
        wr(amcof_pkg::ADDR_RST, 8'h80);
        chk(dcs_on, 1'b0);
        rdreg(amcof_pkg::ADDR_RST, rd);
        chk(rd, 8'h00);
    endtask
    task automatic t_fmt();
        logic [15:0] a, b, ea, eb;
        logic        ck;
        a = 16'h1235;
        b = 16'h0f0e;
        for (int m = 0; m < 4; m++) begin
            wr(amcof_pkg::ADDR_FMT, 8'(m << 1));
            ea = a ^ (m[0] ? {{15{a[0]}}, 1'b0} : 16'h0000);
            eb = b ^ (m[0] ? {{15{b[0]}}, 1'b0} : 16'h0000);
            ck = ~odc;
            smp(a, 1'b1, b, 1'b0);
            chk(o1, m[1] ? ea ^ amcof_pkg::ODD_MASK : ea);
            chk(o2 ^ (m[1] ? amcof_pkg::ODD_MASK : 16'h0000), eb);
            chk({of1, of2}, 2'b10);
            chk(odc, ck);
        end
    endtask
    task automatic t_pattern();
        logic [16:0] s1, s2;
        for (int c = 0; c < 4; c++) begin
            wr(amcof_pkg::ADDR_FMT, 8'((c << amcof_pkg::FMT_TP) | 8'h0f));
            smp(16'h1234, 1'b0, 16'h1234, 1'b0);
            s1 = {of1, o1};
            smp(16'h1235, 1'b0, 16'h1235, 1'b0);
            s2 = {of1, o1};
            chk({of2, o2}, s2);
            // an even count of samples since reset puts the first one of each pair on the ones phase
            case (c)
                0: chk(s1 & s2, 17'h1ffff);
                1: chk(s1 | s2, 17'h00000);
                2: chk(s1, 17'h1ffff);
                default: chk(s1, 17'h15555);
            endcase
            if (c >= 2) chk(s2, 17'(~s1));
        end
        wr(amcof_pkg::ADDR_FMT, 8'h00);
    endtask
    task automatic t_power();
        wr(amcof_pkg::ADDR_DRV, 8'h7e);
        chk(oen, 1'b0);
        chk({lvds_current, lvds_term_on, output_mode}, 6'h3e);
        // every power code is checked while the disable bit is set; oen is checked only before and after the loop
        for (int c = 1; c < 5; c++) begin
            wr(amcof_pkg::ADDR_PWR, 8'(c & 3));
            chk_pwr(2'(c & 3));
        end
        wr(amcof_pkg::ADDR_DRV, 8'h00);
        chk(oen, 1'b1);
        // sleep recovery is never timed here: data after sleep is not judged
        repeat (100) smp(16'h0000, 1'b0, 16'h0000, 1'b0);
    endtask
    task automatic t_read();
        logic [7:0] rd;
        wr(amcof_pkg::ADDR_FMT, 8'h5a);
        rdreg(amcof_pkg::ADDR_FMT, rd);
        chk(rd, 8'h5a);
        rdreg(amcof_pkg::ADDR_FMT, rd);
        chk(rd, 8'h5a);
        rdreg(7'h7f, rd);
        chk(rd, 8'h00);
        wr(amcof_pkg::ADDR_FMT, 8'h00);
    endtask
    task automatic t_frame();
        logic [7:0] rd;
        amcof_host_i.xfer({1'b0, amcof_pkg::ADDR_TIM, 8'h01}, 15, rd);
        chk(dcs_on, 1'b0);
        amcof_host_i.xfer({1'b0, amcof_pkg::ADDR_TIM, 8'h01}, 20, rd);
        rdreg(amcof_pkg::ADDR_TIM, rd);
        chk(rd, 8'h01);
        chk(dcs_on, 1'b1);
    endtask
    task automatic t_parallel();
        logic [3:0] p;
        psel <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            p = 4'(i);
            amcof_host_i.strap(p[3], p[2], p[1]);
            strap_sdo <= p[0];
            repeat (8) @(posedge mclk);
            #1;
            chk(dcs_on, p[3]);
            chk(output_mode, p[2] ? amcof_pkg::MODE_LVDS : amcof_pkg::MODE_CMOS);
            chk({lvds_current, lvds_term_on}, {amcof_pkg::CUR_3P5, 1'b0});
            chk_pwr(p[1:0]);
        end
        amcof_host_i.strap(1'b1, 1'b0, 1'b0);
        psel <= 1'b0;
    endtask
    initial begin
        rst          = 1'b1;
        ce           = 1'b1;
        psel         = 1'b0;
        strap_sdo    = 1'b0;
        sample_valid = 1'b0;
        ch1_data     = 16'h0000;
        ch2_data     = 16'h0000;
        ch1_ovf      = 1'b0;
        ch2_ovf      = 1'b0;
        miscompares  = 0;
        total_checks = 0;
        cycles       = 0;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        repeat (6) @(posedge mclk);
        t_reset();
        t_fmt();
        t_pattern();
        t_power();
        t_read();
        t_frame();
        t_parallel();
        final_report();
    end
endmodule
